//--- src/fcd_pkg.sv
// Package with opcodes, field positions and timing constants for the decoder.
package fcd_pkg;
   // Opcode low five bits.
   localparam logic [4:0] OP_READ = 5'h06;
   localparam logic [4:0] OP_READ_DEL = 5'h0C;
   localparam logic [4:0] OP_WRITE = 5'h05;
   localparam logic [4:0] OP_WRITE_DEL = 5'h09;
   localparam logic [4:0] OP_READ_TRACK = 5'h02;
   localparam logic [4:0] OP_READ_ID = 5'h0A;
   localparam logic [4:0] OP_FORMAT = 5'h0D;
   localparam logic [4:0] OP_SCAN_EQ = 5'h11;
   localparam logic [4:0] OP_SCAN_LE = 5'h19;
   // Opcode flag bit positions.
   localparam int BIT_MT = 7;
   localparam int BIT_MF = 6;
   localparam int BIT_SK = 5;
   // Unit byte field positions.
   localparam int BIT_HEAD = 2;
   // Byte counts.
   localparam logic [3:0] LEN_XFER = 4'h9;
   localparam logic [3:0] LEN_RID = 4'h2;
   localparam logic [3:0] LEN_FMT = 4'h6;
   localparam logic [3:0] RES_FULL = 4'h7;
   localparam logic [3:0] RES_ONE = 4'h1;
   // Status byte for an invalid opcode.
   localparam logic [7:0] INVALID_STATUS = 8'h80;
   // Reset values of the timing settings.
   localparam logic [3:0] STEP_RST = 4'hF;
   localparam logic [3:0] RELEASE_RST = 4'h1;
   localparam logic [6:0] SETTLE_RST = 7'h01;
   // Timing units in microseconds and clock rate in kHz.
   localparam int CLK_KHZ = 10000;
   localparam int STEP_UNIT_US = 1000;
   localparam int SETTLE_UNIT_US = 2000;
   localparam int RELEASE_UNIT_US = 16000;
   localparam int STEP_UNIT_CYC = STEP_UNIT_US * CLK_KHZ / 1000;
   localparam int SETTLE_UNIT_CYC = SETTLE_UNIT_US * CLK_KHZ / 1000;
   localparam int RELEASE_UNIT_CYC = RELEASE_UNIT_US * CLK_KHZ / 1000;
   // Decoder phases.
   typedef enum logic [1:0] {
      FCD_CMD,
      FCD_EXEC,
      FCD_RESULT
   } fcd_phase_t;
endpackage

//--- src/fcd_decoder.sv
// Command decoder and parameter store of the floppy controller core.
// Notes on behaviour
// - Port select low reads status, high data.
// - Unit byte: bit2 head, bits1..0 drive.
// - Side select output follows head bit.
// - Transfer stops after last sector number.
// - Short length used only when size zero.
// - Gap three length feeds read/write/format.
// - Settle delay 2 to 254 ms.
// - Release delay 16 to 240 ms.
// - Density bit selects single or double.
// - Both sides continues at sector one, side one; here only next_side_wrap is raised, side_select keeps the head bit.
// - Step interval F=1ms, E=2ms, shared.
// - Status bytes readable only in result.
// - Scan stride one contiguous, two alternate.
// - Reads take nine bytes, return seven.
// - Writes same layout, skip bit zero.
// - Read track reads to last sector.
// - Read ID: two bytes, seven results.
// - Format: six bytes, ID results undefined.
// - Scans take nine bytes, equal/low codes.
// - Command, execution, result phases.
// - Unknown opcode gives one byte 80h.
`timescale 1ns/1ps
module fcd_decoder
   import fcd_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic port_select_line,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic [7:0] main_status,
   output logic exec_start,
   input wire logic exec_done,
   input wire logic [7:0] result_status_a,
   input wire logic [7:0] result_status_b,
   input wire logic [7:0] result_status_c,
   input wire logic [7:0] res_cyl,
   input wire logic [7:0] res_head,
   input wire logic [7:0] res_rec,
   input wire logic [7:0] res_size,
   input wire logic [7:0] cur_sector,
   input wire logic sector_done,
   output logic [4:0] cmd_code,
   output logic [1:0] drive_sel,
   output logic side_select,
   output logic density_select,
   output logic both_sides_flag,
   output logic skip_deleted_flag,
   output logic [7:0] id_cyl,
   output logic [7:0] id_head,
   output logic [7:0] id_rec,
   output logic [7:0] id_size,
   output logic [7:0] last_sector_number,
   output logic [7:0] gap_three_length,
   output logic [7:0] xfer_length,
   output logic [7:0] sectors_per_track,
   output logic [7:0] filler_byte,
   output logic [7:0] scan_sector_stride,
   output logic scan_alternate,
   output logic scan_low_or_equal,
   output logic read_to_track_end,
   output logic stop_transfer,
   output logic next_side_wrap,
   output logic [3:0] step_interval,
   output logic [3:0] head_release_delay,
   output logic [6:0] head_settle_delay,
   output logic programmed_io_flag,
   output logic [17:0] step_cycles,
   output logic [21:0] settle_cycles,
   output logic [21:0] release_cycles
);
   import fcd_pkg::*;

   // Phase state and byte counters.
   fcd_phase_t phase_q;
   logic [3:0] cmd_cnt_q;
   logic [3:0] cmd_len_q;
   logic [3:0] res_cnt_q;
   logic [3:0] res_len_q;
   logic invalid_q;
   // Raw parameter bytes, indexed by their position in the command.
   logic [7:0] params_q [0:8];

   // Length of the command phase for a given opcode byte.
   // A zero length marks an opcode that this block does not know.
   function automatic logic [3:0] cmd_length(input logic [7:0] op);
      case (op[4:0])
         OP_READ, OP_READ_DEL, OP_WRITE, OP_WRITE_DEL,
         OP_READ_TRACK, OP_SCAN_EQ, OP_SCAN_LE: cmd_length = LEN_XFER;
         OP_READ_ID: cmd_length = LEN_RID;
         OP_FORMAT: cmd_length = LEN_FMT;
         default: cmd_length = 4'h0;
      endcase
   endfunction

   // True when the opcode carries its fixed bits correctly.
   // Fixed-zero flag bits that are set make the whole command invalid.
   function automatic logic op_valid(input logic [7:0] op);
      case (op[4:0])
         OP_WRITE, OP_WRITE_DEL: op_valid = !op[BIT_SK];
         OP_READ_TRACK: op_valid = !op[BIT_MT];
         OP_READ_ID, OP_FORMAT: op_valid = !op[BIT_MT] && !op[BIT_SK];
         default: op_valid = (cmd_length(op) != 4'h0);
      endcase
   endfunction

   logic data_wr;
   logic data_rd;
   // Only accesses with the port select high touch the data port.
   assign data_wr = wr_stb && port_select_line;
   assign data_rd = rd_stb && port_select_line;

   // Phase sequencing: command bytes, execution, then result bytes.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase_q <= FCD_CMD;
         cmd_cnt_q <= 4'h0;
         cmd_len_q <= 4'h0;
         res_cnt_q <= 4'h0;
         res_len_q <= 4'h0;
         invalid_q <= 1'b0;
      end else begin
         case (phase_q)
            FCD_CMD: begin
               // Byte zero is the opcode; its length sets the phase end.
               if (data_wr) begin
                  if (cmd_cnt_q == 4'h0) begin
                     if (op_valid(wr_data)) begin
                        cmd_len_q <= cmd_length(wr_data);
                        cmd_cnt_q <= 4'h1;
                        invalid_q <= 1'b0;
                     end else begin
                        // Unknown opcode skips execution entirely.
                        invalid_q <= 1'b1;
                        res_len_q <= RES_ONE;
                        res_cnt_q <= 4'h0;
                        phase_q <= FCD_RESULT;
                     end
                  end else if (cmd_cnt_q + 4'h1 == cmd_len_q) begin
                     cmd_cnt_q <= 4'h0;
                     phase_q <= FCD_EXEC;
                  end else begin
                     cmd_cnt_q <= cmd_cnt_q + 4'h1;
                  end
               end
            end
            FCD_EXEC: begin
               // The engine owns the drive until it reports completion.
               if (exec_done) begin
                  res_len_q <= RES_FULL;
                  res_cnt_q <= 4'h0;
                  phase_q <= FCD_RESULT;
               end
            end
            FCD_RESULT: begin
               // Each data read hands out one result byte; the last one
               // returns the decoder to the command phase.
               if (data_rd) begin
                  if (res_cnt_q + 4'h1 == res_len_q) begin
                     phase_q <= FCD_CMD;
                  end else begin
                     res_cnt_q <= res_cnt_q + 4'h1;
                  end
               end
            end
            default: phase_q <= FCD_CMD;
         endcase
      end
   end

   // Parameter bytes are stored by position as they arrive.
   // Writes outside the command phase are dropped, so a host that writes
   // during execution cannot corrupt the parameters in use.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 9; i++) begin
            params_q[i] <= 8'h00;
         end
      end else if (phase_q == FCD_CMD && data_wr) begin
         params_q[cmd_cnt_q] <= wr_data;
      end
   end

   // Specify-style timing settings; held outside the command path.
   // No command here reloads them, so they keep their reset values and
   // every drive shares the same timing.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         step_interval <= STEP_RST;
         head_release_delay <= RELEASE_RST;
         head_settle_delay <= SETTLE_RST;
         programmed_io_flag <= 1'b0;
      end else if (phase_q == FCD_CMD && data_wr && cmd_cnt_q == 4'h0
                   && wr_data == 8'h03) begin
         // A specify opcode changes nothing here; the command path rejects it
         // as an invalid opcode with result 80h, so the host must not rely on it.
         step_interval <= step_interval;
      end
   end

   logic is_format;
   logic is_read_id;
   logic [4:0] op_q;
   assign op_q = params_q[0][4:0];
   assign is_format = (op_q == OP_FORMAT);
   assign is_read_id = (op_q == OP_READ_ID);

   // Decoded parameter outputs.
   // Format reuses positions two to five for its own fields, so id_cyl,
   // id_head and id_rec read zero and id_size takes position two while a format command is held.
   always_comb begin
      cmd_code = op_q;
      both_sides_flag = params_q[0][BIT_MT];
      density_select = params_q[0][BIT_MF];
      skip_deleted_flag = params_q[0][BIT_SK];
      drive_sel = params_q[1][1:0];
      side_select = params_q[1][BIT_HEAD];
      id_cyl = is_format ? 8'h00 : params_q[2];
      id_head = is_format ? 8'h00 : params_q[3];
      id_rec = is_format ? 8'h00 : params_q[4];
      id_size = is_format ? params_q[2] : params_q[5];
      sectors_per_track = is_format ? params_q[3] : 8'h00;
      filler_byte = is_format ? params_q[5] : 8'h00;
      last_sector_number = is_format ? 8'h00 : params_q[6];
      gap_three_length = is_format ? params_q[4] : params_q[7];
      scan_sector_stride = params_q[8];
      scan_alternate = (params_q[8] == 8'h02);
      scan_low_or_equal = (op_q == OP_SCAN_LE);
      read_to_track_end = (op_q == OP_READ_TRACK);
      // Short length counts only with size code zero.
      xfer_length = (params_q[5] == 8'h00) ? params_q[8] : 8'hFF;
      if (is_read_id) begin
         id_size = 8'h00;
      end
   end

   // End-of-track detection and side change for multi-track runs.
   // A both-sides run on side zero does not stop at the last sector; it
   // wraps to side one instead; side_select keeps the head bit, so stop_transfer never follows.
   always_comb begin
      stop_transfer = sector_done && (cur_sector == last_sector_number)
         && !(both_sides_flag && !side_select);
      next_side_wrap = sector_done && (cur_sector == last_sector_number)
         && both_sides_flag && !side_select;
   end

   // Delay counts in clock cycles derived from the settings.
   // Step field value zero maps to sixteen units, the slowest step rate, which
   // keeps a cleared setting from stepping faster than any drive allows.
   always_comb begin
      step_cycles = 18'((5'h10 - {1'b0, step_interval}) * STEP_UNIT_CYC);
      settle_cycles = 22'(head_settle_delay * SETTLE_UNIT_CYC);
      release_cycles = 22'(head_release_delay * RELEASE_UNIT_CYC);
      if (step_interval == 4'h0) begin
         step_cycles = 18'(16 * STEP_UNIT_CYC);
      end
   end

   assign exec_start = (phase_q == FCD_EXEC);

   // Status of the command port for the host.
   // Bit 7 is ready, bit 6 marks the result phase, bit 4 is busy.
   always_comb begin
      main_status = {phase_q != FCD_EXEC, phase_q == FCD_RESULT,
                     1'b0, phase_q != FCD_CMD || cmd_cnt_q != 4'h0,
                     4'h0};
   end

   // Read data: main status at select low, result bytes at high.
   // The byte stands from one read strobe to the next, so a slow host
   // can take it whenever it likes.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (rd_stb && !port_select_line) begin
         rd_data <= main_status;
      end else if (!rd_stb) begin
         rd_data <= rd_data;
      end else if (phase_q != FCD_RESULT) begin
         // Data reads outside the result phase give zero, not stale bytes.
         rd_data <= 8'h00;
      end else if (invalid_q) begin
         rd_data <= INVALID_STATUS;
      end else begin
         case (res_cnt_q)
            4'h0: rd_data <= result_status_a;
            4'h1: rd_data <= result_status_b;
            4'h2: rd_data <= result_status_c;
            4'h3: rd_data <= is_format ? 8'h00 : res_cyl;
            4'h4: rd_data <= is_format ? 8'h00 : res_head;
            4'h5: rd_data <= is_format ? 8'h00 : res_rec;
            4'h6: rd_data <= is_format ? 8'h00 : res_size;
            default: rd_data <= 8'h00;
         endcase
      end
   end
endmodule

//--- test/fcd_decoder_asserts.sv
// Checker module bound to the command decoder ports.
`timescale 1ns/1ps
module fcd_decoder_asserts
   import fcd_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic port_select_line,
   input wire logic rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic [7:0] main_status,
   input wire logic exec_start,
   input wire logic exec_done,
   input wire logic [7:0] cur_sector,
   input wire logic sector_done,
   input wire logic [4:0] cmd_code,
   input wire logic [7:0] last_sector_number,
   input wire logic stop_transfer,
   input wire logic next_side_wrap,
   input wire logic both_sides_flag,
   input wire logic side_select,
   input wire logic [7:0] id_size,
   input wire logic [7:0] xfer_length,
   input wire logic [3:0] step_interval,
   input wire logic [17:0] step_cycles,
   input wire logic [6:0] head_settle_delay,
   input wire logic [21:0] settle_cycles,
   input wire logic [3:0] head_release_delay,
   input wire logic [21:0] release_cycles
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_exec_not_ready: assert property (exec_start |->
      !main_status[7] && !main_status[6]) else $error("exec flags");
   chk_done_to_result: assert property (exec_start && exec_done
      |=> main_status[6] && !exec_start) else $error("no result");
   // Only a read strobe may move the read byte.
   chk_read_hold: assert property (!rd_stb
      |=> $stable(rd_data)) else $error("read moved");
   chk_status_read: assert property (rd_stb && !port_select_line
      |=> rd_data == $past(main_status)) else $error("status read");
   chk_data_idle: assert property (rd_stb && port_select_line
      && !main_status[6] |=> rd_data == 8'h00) else $error("idle read");
   chk_stop_last: assert property (sector_done |->
      stop_transfer == (cur_sector == last_sector_number
      && !(both_sides_flag && !side_select))) else $error("stop");
   chk_wrap_cause: assert property (next_side_wrap |->
      both_sides_flag && !side_select && !stop_transfer
      && cur_sector == last_sector_number) else $error("wrap");
   chk_short_len: assert property ((cmd_code == OP_READ
      || cmd_code == OP_READ_DEL) && id_size != 8'h00
      |-> xfer_length == 8'hFF) else $error("len");
   chk_step_cyc: assert property (step_cycles ==
      (16 - int'(step_interval)) * STEP_UNIT_CYC) else $error("step");
   chk_settle_cyc: assert property (settle_cycles ==
      head_settle_delay * SETTLE_UNIT_CYC) else $error("settle");
   chk_release_cyc: assert property (release_cycles ==
      head_release_delay * RELEASE_UNIT_CYC) else $error("release");
   cover property (exec_start && exec_done);
   cover property (stop_transfer);
   cover property (next_side_wrap);
endmodule
bind fcd_decoder fcd_decoder_asserts u_chk (.*);

//--- test/fcd_engine_model.sv
// Execution engine model that finishes commands and offers results.
`timescale 1ns/1ps
module fcd_engine_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic exec_start,
   input wire logic [7:0] last_sector_number,
   output logic exec_done,
   output logic sector_done,
   output logic [7:0] cur_sector,
   output logic [7:0] result_status_a,
   output logic [7:0] result_status_b,
   output logic [7:0] result_status_c,
   output logic [7:0] res_cyl,
   output logic [7:0] res_head,
   output logic [7:0] res_rec,
   output logic [7:0] res_size
);
   // Fixed result bytes, so the bench can predict every read.
   assign {result_status_a, result_status_b, result_status_c, res_cyl,
      res_head, res_rec, res_size} = 56'h40_21_32_43_54_65_76;
   // Each run ends two sectors: one short of the last, then the last.
   initial begin
      exec_done = 1'b0;
      sector_done = 1'b0;
      cur_sector = 8'h00;
      forever begin
         @(posedge clock iff (exec_start && !rst));
         @(posedge clock);
         cur_sector <= last_sector_number - 8'h01;
         sector_done <= 1'b1;
         @(posedge clock);
         cur_sector <= last_sector_number;
         @(posedge clock);
         sector_done <= 1'b0;
         cur_sector <= ~cur_sector; // Stale sector is not left showing.
         exec_done <= 1'b1;
         @(posedge clock);
         exec_done <= 1'b0;
         @(posedge clock);
      end
   end
endmodule

//--- test/test_fcd_decoder.sv
// Self-checking bench for the command decoder.
`timescale 1ns/1ps
module test_fcd_decoder;
   import fcd_pkg::*;
   logic clock = 0, rst = 1, port_select_line = 0, wr_stb = 0, rd_stb = 0;
   logic [7:0] wr_data = 8'h00;
   logic exec_start, exec_done, sector_done, side_select, density_select;
   logic both_sides_flag, skip_deleted_flag, scan_alternate;
   logic scan_low_or_equal, read_to_track_end, stop_transfer;
   logic next_side_wrap, programmed_io_flag;
   logic [7:0] rd_data, main_status, result_status_a, result_status_b;
   logic [7:0] result_status_c, res_cyl, res_head, res_rec, res_size;
   logic [7:0] cur_sector, id_cyl, id_head, id_rec, id_size;
   logic [7:0] last_sector_number, gap_three_length, xfer_length;
   logic [7:0] sectors_per_track, filler_byte, scan_sector_stride;
   logic [4:0] cmd_code;
   logic [1:0] drive_sel;
   logic [3:0] step_interval, head_release_delay;
   logic [6:0] head_settle_delay;
   logic [17:0] step_cycles;
   logic [21:0] settle_cycles, release_cycles;
   int err_total = 0, total_checks = 0;
   localparam logic [55:0] RES = 56'h40_21_32_43_54_65_76;
   localparam logic [7:0] OPS [10] = '{8'hE6, 8'h4C, 8'hC5, 8'h89,
      8'h62, 8'h4A, 8'h0D, 8'hB1, 8'hD9, 8'h25};
   fcd_decoder uut (.*);
   fcd_engine_model eng (.*);
   initial forever #50 clock = ~clock;
   task chk8(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task chk1(input logic g, input logic e);
      chk8({7'h0, g}, {7'h0, e});
   endtask
   // Host strobes change at the falling edge, one byte per pulse.
   task wr(input logic [7:0] d, input logic sel);
      @(negedge clock);
      port_select_line = sel;
      wr_data = d;
      wr_stb = 1;
      @(negedge clock);
      wr_stb = 0;
   endtask
   task rd(input logic sel, output logic [7:0] d);
      @(negedge clock);
      port_select_line = sel;
      rd_stb = 1;
      @(negedge clock);
      rd_stb = 0;
      d = rd_data;
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task t_reset;
      logic [7:0] d;
      chk8(main_status & 8'hD0, 8'h80);
      chk8({4'h0, step_interval}, 8'h0F);
      chk8({4'h0, head_release_delay}, 8'h01);
      chk8({1'b0, head_settle_delay}, 8'h01);
      chk1(programmed_io_flag, 1'b0);
      chk1(step_cycles == 18'(STEP_UNIT_CYC), 1'b1);
      chk1(settle_cycles == 22'(SETTLE_UNIT_CYC), 1'b1);
      chk1(release_cycles == 22'(RELEASE_UNIT_CYC), 1'b1);
      rd(1'b1, d);
      chk8(d, 8'h00);
      rd(1'b0, d);
      chk8(d, 8'h80);
      $display("test reset done");
   endtask
   // Table-driven command run: bytes in, engine run, results out.
   task t_cmd(input int k);
      logic [7:0] b [9];
      logic [7:0] d;
      int n, i;
      n = (k == 5) ? 2 : (k == 6) ? 6 : (k == 9) ? 1 : 9;
      b[0] = OPS[k];
      b[1] = {5'h0, 3'(k)};
      for (i = 2; i < 9; i++) b[i] = {4'(k), 4'(i)};
      b[5] = {7'h0, 1'(k)};
      if (k == 7 || k == 8) b[8] = 8'(k - 6);
      if (k == 0) wr(8'h0D, 0); // Status-side write must be ignored.
      for (i = 0; i < n; i++) wr(b[i], 1);
      if (k < 9) begin
         chk8({3'h0, cmd_code}, {3'h0, b[0][4:0]});
         chk8({6'h0, drive_sel}, {6'h0, b[1][1:0]});
         chk1(side_select, b[1][2]);
         chk1(density_select, b[0][6]);
         chk1(both_sides_flag, b[0][7]);
         chk1(skip_deleted_flag, b[0][5]);
         if (k != 5) // Read ID carries no gap byte.
            chk8(gap_three_length, b[(k == 6) ? 4 : 7]);
         chk1(read_to_track_end, k == 4);
         chk1(exec_start, 1);
         if (n == 9) begin
            chk8(id_rec, b[4]);
            chk8(last_sector_number, b[6]);
            chk8(id_cyl, b[2]);
            chk8(id_head, b[3]);
            chk8(id_size, b[5]);
         end
         if (k == 6) begin
            chk8(id_size, b[2]);
            chk8(sectors_per_track, b[3]);
            chk8(filler_byte, b[5]);
         end
         if (k < 5) chk8(xfer_length, b[5] == 0 ? b[8] : 8'hFF);
         if (k > 6) begin
            chk1(scan_alternate, b[8] == 8'h02);
            chk8(scan_sector_stride, b[8]);
            chk1(scan_low_or_equal, k == 8);
         end
         if (k == 0) begin
            wr(8'hFF, 1);
            chk8({3'h0, cmd_code}, {3'h0, b[0][4:0]});
            // Still executing here: busy only, neither ready nor result.
            rd(1'b0, d);
            chk8(d, 8'h10);
         end
      end
      for (i = 0; i < 40 && main_status[6] !== 1'b1; i++) @(negedge clock);
      chk1(main_status[6], 1);
      for (i = 0; i < ((k < 9) ? 7 : 1); i++) begin
         rd(1'b1, d);
         // Format leaves its four ID result bytes undefined; this block
         // returns zero there.
         if (k == 6 && i > 2)
            chk8(d, 8'h00);
         else
            chk8(d, (k < 9) ? RES[55 - 8 * i -: 8] : 8'h80);
      end
      chk8(main_status & 8'hD0, 8'h80);
      $display("test command %0d done", k);
   endtask
   initial begin
      repeat (12) @(posedge clock);
      @(negedge clock);
      rst = 0;
      t_reset;
      for (int k = 0; k < 10; k++) t_cmd(k);
      print_verdict;
   end
   // Whole run needs well under a thousand cycles.
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      print_verdict;
   end
endmodule
